// ### logic/cpm_ctrl.sv
// power ratio, peak detector and mode control with an apb register file
// assumes front-end results and peak samples arrive on pclk; straps are
// asynchronous pins; open-drain outputs are resolved outside
`include "cpm_regs.svh"

// What this block does
// - ratio is magnitude product, 16-bit left aligned
// - ratio refreshed on every new sense/source reading
// - code 65535 means full-scale power
// - over threshold starts timer; duration trips output
// - output and flag follow peak until it ends
// - peak drives alert only in comparator mode
// - timer resets only after filter interval below
// - peaks of either polarity are detected
// - peak detector independent of averaged conversions
// - threshold strap at power-up, host may overwrite
// - duration strap at power-up, host may overwrite
// - fully active converts all; one-shot ignored
// - current-only mode; one-shot updates temperature once
// - temperature-only mode; one-shot updates sense/source
// - standby stops updates, registers stay accessible
// - standby one-shot updates all, then back idle
// - sense result is signed 11-bit
// - source result is unsigned 11-bit
module cpm_ctrl #(
   parameter int MS_CYCLES = `CPM_MS_CYC,
   parameter int FILTER_CYCLES = `CPM_FILTER_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] threshold_strap,
   input wire logic [3:0] duration_strap,
   input wire logic signed [7:0] peak_sample_mv,
   input wire logic [10:0] sense_data,
   input wire logic sense_valid,
   input wire logic [10:0] source_data,
   input wire logic source_valid,
   input wire logic [10:0] temp_data,
   input wire logic temp_valid,
   output logic vi_conv_en,
   output logic temp_conv_en,
   output logic vi_limit_chk,
   output logic temp_limit_chk,
   output logic crit_out_n_o,
   output logic crit_out_n_oe,
   output logic alert_n_o,
   output logic alert_n_oe
);
   localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);
   localparam logic [15:0] FILT_LAST = 16'(FILTER_CYCLES);
   // duration choices in ms
   localparam logic [12:0] DUR_MS [16] = '{
      13'h0001, 13'h0005, 13'h001A, 13'h0033, 13'h004D, 13'h0066,
      13'h0080, 13'h0100, 13'h0180, 13'h0200, 13'h0300, 13'h0400,
      13'h0600, 13'h0800, 13'h0C00, 13'h1000};

   cpm_pkg::cpm_state_t st_reg;
   cpm_pkg::cpm_state_t st_next;
   cpm_pwr_if pwr ();

   logic [`CPM_AW-1:0] addr;
   logic wr_acc;
   logic mapped;
   logic oneshot_wr;
   logic [7:0] peak_mag;
   logic [7:0] th_mv;
   logic over;
   logic running;
   logic ms_tick;
   logic dur_hit;
   logic tripped;
   logic vi_take;
   logic temp_take;
   logic sense_take;
   logic source_take;
   logic alert_drive;

   ////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states, unmapped offsets answer with error
   assign addr = paddr[`CPM_AW-1:0];
   always_comb begin
      case (addr)
         `CPM_OFF_CONFIG, `CPM_OFF_ONESHOT, `CPM_OFF_PEAKCFG,
         `CPM_OFF_STATUS, `CPM_OFF_SENSE, `CPM_OFF_SOURCE,
         `CPM_OFF_TEMP, `CPM_OFF_POWER: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr_acc = psel & penable & pwrite;
   assign oneshot_wr = wr_acc && addr == `CPM_OFF_ONESHOT;
   assign prdata = st_reg.prdata;

   ////////////////////////////////////////////////////////////////////
   // peak comparison, works on the raw sample, not on averaged results
   assign peak_mag = peak_sample_mv[7] ? 8'(-peak_sample_mv)
                                       : 8'(peak_sample_mv);
   assign th_mv = `CPM_TH_BASE_MV
                  + 8'(st_reg.th_idx * `CPM_TH_STEP_MV);
   assign over = peak_mag > th_mv;
   assign tripped = st_reg.pstate == cpm_pkg::CPM_P_TRIP
                    || st_reg.pstate == cpm_pkg::CPM_P_TRIP_HOLD;
   assign running = st_reg.pstate == cpm_pkg::CPM_P_RUN
                    || st_reg.pstate == cpm_pkg::CPM_P_HOLD;
   assign ms_tick = running && st_reg.ms_cnt == MS_LAST;
   assign dur_hit = ms_tick
                    && st_reg.dur_cnt + 13'h0001 == DUR_MS[st_reg.dur_idx];

   // alert only follows a peak when comparator mode and linked
   assign alert_drive = tripped & st_reg.alert_comp
                        & st_reg.peak_link;
   assign crit_out_n_oe = tripped;
   assign crit_out_n_o = ~tripped;
   assign alert_n_oe = alert_drive;
   assign alert_n_o = ~alert_drive;

   ////////////////////////////////////////////////////////////////////
   // which results the current mode or a pending one-shot lets through
   always_comb begin
      vi_take = st_reg.mode == cpm_pkg::CPM_ACTIVE
                || st_reg.mode == cpm_pkg::CPM_CUR_ONLY;
      temp_take = st_reg.mode == cpm_pkg::CPM_ACTIVE
                  || st_reg.mode == cpm_pkg::CPM_TEMP_ONLY;
      sense_take = sense_valid & (vi_take | st_reg.pend_sense);
      source_take = source_valid & (vi_take | st_reg.pend_source);
      temp_take = temp_valid & (temp_take | st_reg.pend_temp);
   end
   assign vi_conv_en = vi_take | st_reg.pend_sense | st_reg.pend_source;
   assign temp_conv_en = st_reg.mode == cpm_pkg::CPM_ACTIVE
                         || st_reg.mode == cpm_pkg::CPM_TEMP_ONLY
                         || st_reg.pend_temp;
   // limit checks run only on results actually stored
   assign vi_limit_chk = sense_take | source_take;
   assign temp_limit_chk = temp_take;

   assign pwr.upd = st_reg.pwr_upd;
   assign pwr.sense = st_reg.sense;
   assign pwr.source = st_reg.source;

   cpm_power_calc u_power (
      .pclk(pclk),
      .presetn(presetn),
      .pwr(pwr)
   );

   ////////////////////////////////////////////////////////////////////
   // next state of the whole block
   always_comb begin
      st_next = st_reg;
      // straps: two flops, captured once shortly after reset release
      st_next.th_s1 = threshold_strap;
      st_next.th_s2 = st_reg.th_s1;
      st_next.du_s1 = duration_strap;
      st_next.du_s2 = st_reg.du_s1;
      if (st_reg.strap_cnt != `CPM_STRAP_WAIT + 2'h1)
         st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
      if (st_reg.strap_cnt == `CPM_STRAP_WAIT) begin
         st_next.th_idx = st_reg.th_s2;
         st_next.dur_idx = st_reg.du_s2;
      end

      // register writes
      if (wr_acc && addr == `CPM_OFF_CONFIG) begin
         st_next.mode = cpm_pkg::cpm_mode_t'(
            pwdata[`CPM_CFG_MODE_LSB +: 2]);
         st_next.alert_comp = pwdata[`CPM_CFG_COMP_BIT];
         st_next.peak_link = pwdata[`CPM_CFG_LINK_BIT];
      end
      if (wr_acc && addr == `CPM_OFF_PEAKCFG) begin
         st_next.th_idx = pwdata[`CPM_PK_TH_LSB +: 4];
         st_next.dur_idx = pwdata[`CPM_PK_DUR_LSB +: 4];
      end

      // result storage; a pending one-shot clears once served
      if (sense_take) begin
         st_next.sense = sense_data;
         st_next.pend_sense = 1'b0;
      end
      if (source_take) begin
         st_next.source = source_data;
         st_next.pend_source = 1'b0;
      end
      if (temp_take) begin
         st_next.temp = temp_data;
         st_next.pend_temp = 1'b0;
      end
      st_next.pwr_upd = sense_take | source_take;

      // one-shot: set wins over a same-cycle clear
      if (oneshot_wr) begin
         case (st_reg.mode)
            cpm_pkg::CPM_CUR_ONLY: st_next.pend_temp = 1'b1;
            cpm_pkg::CPM_TEMP_ONLY: begin
               st_next.pend_sense = 1'b1;
               st_next.pend_source = 1'b1;
            end
            cpm_pkg::CPM_STANDBY: begin
               st_next.pend_sense = 1'b1;
               st_next.pend_source = 1'b1;
               st_next.pend_temp = 1'b1;
            end
            default: ; // fully active ignores the write
         endcase
      end

      // duration timer runs while a peak is in progress
      if (running) begin
         st_next.ms_cnt = ms_tick ? 17'h00000 : st_reg.ms_cnt + 17'h00001;
         if (ms_tick)
            st_next.dur_cnt = st_reg.dur_cnt + 13'h0001;
      end

      // peak detector
      case (st_reg.pstate)
         cpm_pkg::CPM_P_IDLE: begin
            st_next.ms_cnt = 17'h00000;
            st_next.dur_cnt = 13'h0000;
            if (over)
               st_next.pstate = cpm_pkg::CPM_P_RUN;
         end
         cpm_pkg::CPM_P_RUN: begin
            if (dur_hit)
               st_next.pstate = over ? cpm_pkg::CPM_P_TRIP
                                     : cpm_pkg::CPM_P_TRIP_HOLD;
            else if (!over) begin
               st_next.pstate = cpm_pkg::CPM_P_HOLD;
               st_next.filt_cnt = 16'h0001;
            end
         end
         cpm_pkg::CPM_P_HOLD: begin
            if (dur_hit)
               st_next.pstate = over ? cpm_pkg::CPM_P_TRIP
                                     : cpm_pkg::CPM_P_TRIP_HOLD;
            else if (over)
               st_next.pstate = cpm_pkg::CPM_P_RUN;
            else if (st_reg.filt_cnt >= FILT_LAST)
               st_next.pstate = cpm_pkg::CPM_P_IDLE;
            else
               st_next.filt_cnt = st_reg.filt_cnt + 16'h0001;
         end
         cpm_pkg::CPM_P_TRIP: begin
            st_next.ms_cnt = 17'h00000;
            if (!over) begin
               st_next.pstate = cpm_pkg::CPM_P_TRIP_HOLD;
               st_next.filt_cnt = 16'h0001;
            end
         end
         cpm_pkg::CPM_P_TRIP_HOLD: begin
            st_next.ms_cnt = 17'h00000;
            if (over)
               st_next.pstate = cpm_pkg::CPM_P_TRIP;
            else if (st_reg.filt_cnt >= FILT_LAST)
               st_next.pstate = cpm_pkg::CPM_P_IDLE;
            else
               st_next.filt_cnt = st_reg.filt_cnt + 16'h0001;
         end
         default: st_next.pstate = cpm_pkg::CPM_P_IDLE;
      endcase

      // read data captured in the setup phase
      if (psel && !penable) begin
         case (addr)
            `CPM_OFF_CONFIG: st_next.prdata = {28'h0000000,
               st_reg.peak_link, st_reg.alert_comp, st_reg.mode};
            `CPM_OFF_PEAKCFG: st_next.prdata = {24'h000000,
               st_reg.dur_idx, st_reg.th_idx};
            `CPM_OFF_STATUS: st_next.prdata = {28'h0000000,
               st_reg.pend_temp, st_reg.pend_source, st_reg.pend_sense,
               tripped};
            `CPM_OFF_SENSE: st_next.prdata = {21'h000000, st_reg.sense};
            `CPM_OFF_SOURCE: st_next.prdata = {21'h000000, st_reg.source};
            `CPM_OFF_TEMP: st_next.prdata = {21'h000000, st_reg.temp};
            `CPM_OFF_POWER: st_next.prdata = {16'h0000, pwr.ratio};
            default: st_next.prdata = 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register; straps default to the open code until captured
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.mode <= cpm_pkg::CPM_ACTIVE;
         st_reg.th_idx <= `CPM_TH_OPEN;
         st_reg.dur_idx <= `CPM_DUR_OPEN;
         st_reg.pstate <= cpm_pkg::CPM_P_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_stored;
      sense_take or source_take;
   endsequence
   // update strobe, then the ratio register takes the fresh product
   sequence s_ratio_out;
      pwr.upd ##1 pwr.ratio == $past(u_power.ratio_next);
   endsequence

   ratio_refresh_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_stored |=> s_ratio_out)
      else $error("ratio not refreshed after new reading");
   // readings of the strobe cycle, a second reading may land meanwhile
   ratio_value_a: assert property (@(posedge pclk) disable iff (!presetn)
      pwr.upd |=> pwr.ratio == 16'(({11'h000, ($past(st_reg.sense[10])
         ? 11'(-$past(st_reg.sense)) : $past(st_reg.sense))}
         * {11'h000, $past(st_reg.source)}) >> 5)
         || pwr.ratio == 16'hFFFF)
      else $error("ratio differs from magnitude product");
   peak_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.pstate == cpm_pkg::CPM_P_IDLE && over
      |=> st_reg.pstate == cpm_pkg::CPM_P_RUN)
      else $error("peak over threshold did not start timer");
   peak_neg_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.pstate == cpm_pkg::CPM_P_IDLE && peak_sample_mv < 0
      && 8'(-peak_sample_mv) > th_mv |=> running)
      else $error("negative peak missed");
   trip_time_a: assert property (@(posedge pclk) disable iff (!presetn)
      dur_hit |=> crit_out_n_oe && !crit_out_n_o)
      else $error("duration reached without critical output");
   peak_release_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.pstate == cpm_pkg::CPM_P_TRIP_HOLD && !over
      && st_reg.filt_cnt >= FILT_LAST |=> !crit_out_n_oe)
      else $error("critical output held after peak ended");
   alert_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      !st_reg.alert_comp |-> !alert_n_oe)
      else $error("peak drove alert in interrupt mode");
   filter_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.pstate == cpm_pkg::CPM_P_RUN && !over && !dur_hit
      |=> st_reg.pstate == cpm_pkg::CPM_P_HOLD && st_reg.dur_cnt
      == $past(st_reg.dur_cnt) + 13'($past(ms_tick)))
      else $error("timer reset before filter interval");
   oneshot_ign_a: assert property (@(posedge pclk) disable iff (!presetn)
      oneshot_wr && st_reg.mode == cpm_pkg::CPM_ACTIVE
      |=> !st_reg.pend_temp && !st_reg.pend_sense)
      else $error("one-shot acted in fully active mode");
   temp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.mode == cpm_pkg::CPM_TEMP_ONLY && !st_reg.pend_sense
      && !oneshot_wr |=> $stable(st_reg.sense))
      else $error("sense changed in temperature-only mode");
   standby_a: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.mode == cpm_pkg::CPM_STANDBY && !st_reg.pend_sense
      && !st_reg.pend_source && !st_reg.pend_temp
      |-> !vi_limit_chk && !temp_limit_chk)
      else $error("update in standby without one-shot");
   stby_shot_a: assert property (@(posedge pclk) disable iff (!presetn)
      oneshot_wr && st_reg.mode == cpm_pkg::CPM_STANDBY
      |=> st_reg.pend_sense && st_reg.pend_source
      && st_reg.pend_temp)
      else $error("standby one-shot did not arm all channels");
endmodule : cpm_ctrl

// ### logic/cpm_pkg.sv
// types shared by the power, peak and mode control block
// assumes the constants in cpm_regs.svh
package cpm_pkg;
   // operating modes, fully active is the reset default
   typedef enum logic [1:0] {
      CPM_ACTIVE = 2'h0,
      CPM_CUR_ONLY = 2'h1,
      CPM_TEMP_ONLY = 2'h2,
      CPM_STANDBY = 2'h3
   } cpm_mode_t;

   // peak detector states, one-hot
   typedef enum logic [4:0] {
      CPM_P_IDLE = 5'h01,
      CPM_P_RUN = 5'h02,
      CPM_P_HOLD = 5'h04,
      CPM_P_TRIP = 5'h08,
      CPM_P_TRIP_HOLD = 5'h10
   } cpm_peak_t;

   // whole state of the main module
   typedef struct packed {
      cpm_mode_t mode;
      logic alert_comp;
      logic peak_link;
      logic [3:0] th_idx;
      logic [3:0] dur_idx;
      logic [3:0] th_s1;
      logic [3:0] th_s2;
      logic [3:0] du_s1;
      logic [3:0] du_s2;
      logic [1:0] strap_cnt;
      logic pend_sense;
      logic pend_source;
      logic pend_temp;
      logic [10:0] sense;
      logic [10:0] source;
      logic [10:0] temp;
      logic pwr_upd;
      cpm_peak_t pstate;
      logic [15:0] filt_cnt;
      logic [16:0] ms_cnt;
      logic [12:0] dur_cnt;
      logic [31:0] prdata;
   } cpm_state_t;
endpackage : cpm_pkg

// ### logic/cpm_power_calc.sv
// power ratio unit: magnitude product, left aligned to 16 bits
// assumes upd is a one-cycle pulse after a reading was stored
module cpm_power_calc (
   input wire logic pclk,
   input wire logic presetn,
   cpm_pwr_if.calc pwr
);
   logic [10:0] mag;
   logic [21:0] prod;
   logic [15:0] ratio_reg;
   logic [15:0] ratio_next;

   // magnitude of the signed sense code; -1024 fits in 11 bits
   always_comb begin
      mag = pwr.sense[10] ? 11'(-pwr.sense) : pwr.sense;
      prod = {11'h000, mag} * {11'h000, pwr.source};
      // top 16 of 21 bits; 1024 x 2048 would be full scale, so clip
      if (prod[21])
         ratio_next = 16'hFFFF;
      else
         ratio_next = pwr.upd ? prod[20:5] : ratio_reg;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ratio_reg <= 16'h0000;
      else
         ratio_reg <= ratio_next;
   end

   assign pwr.ratio = ratio_reg;
endmodule : cpm_power_calc

// ### logic/cpm_pwr_if.sv
// carries stored readings to the power ratio unit and the ratio back
// assumes both ends on pclk
interface cpm_pwr_if;
   logic upd;
   logic [10:0] sense;
   logic [10:0] source;
   logic [15:0] ratio;
   modport req (output upd, output sense, output source, input ratio);
   modport calc (input upd, input sense, input source, output ratio);
endinterface : cpm_pwr_if

// ### logic/cpm_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave decoding paddr[11:0], one word per register
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH
`define CPM_AW 12
`define CPM_OFF_CONFIG 12'h000
`define CPM_OFF_ONESHOT 12'h004
`define CPM_OFF_PEAKCFG 12'h008
`define CPM_OFF_STATUS 12'h00C
`define CPM_OFF_SENSE 12'h010
`define CPM_OFF_SOURCE 12'h014
`define CPM_OFF_TEMP 12'h018
`define CPM_OFF_POWER 12'h01C
`define CPM_CFG_MODE_LSB 0
`define CPM_CFG_COMP_BIT 2
`define CPM_CFG_LINK_BIT 3
`define CPM_PK_TH_LSB 0
`define CPM_PK_DUR_LSB 4
`define CPM_TH_OPEN 4'hF
`define CPM_DUR_OPEN 4'hF
`define CPM_TH_BASE_MV 8'h0A
`define CPM_TH_STEP_MV 8'h05
`define CPM_CLK_MHZ 125
`define CPM_TICK_US 1000
`define CPM_MS_CYC (`CPM_CLK_MHZ * `CPM_TICK_US)
`define CPM_FILTER_CYC 16
`define CPM_STRAP_WAIT 2'h2
`endif

// ### tb/cpm_front_model.sv
// front-end model: periodic sense, source and temperature results
// assumes pclk domain; converts only while the block enables it
module cpm_front_model #(
   parameter int PERIOD = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic vi_en,
   input wire logic t_en,
   input wire logic [10:0] sense_val,
   input wire logic [10:0] source_val,
   input wire logic [10:0] temp_val,
   output logic [10:0] sense_data,
   output logic sense_valid,
   output logic [10:0] source_data,
   output logic source_valid,
   output logic [10:0] temp_data,
   output logic temp_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   //////////////////////////////////////////////////////////////////////
   // one conversion slot per channel in each period
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cnt <= 0;
      else
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
   end
   assign sense_valid = vi_en && cnt == 0;
   assign source_valid = vi_en && cnt == 1;
   assign temp_valid = t_en && cnt == 2;
   // junk between results so a late capture shows up
   assign sense_data = sense_valid ? sense_val : ~sense_val;
   assign source_data = source_valid ? source_val : ~source_val;
   assign temp_data = temp_valid ? temp_val : ~temp_val;
endmodule : cpm_front_model

// ### tb/tb_cpm_ctrl.sv
// self-checking bench for cpm_ctrl over apb with a front-end model
// assumes the register map in cpm_regs.svh
`include "cpm_regs.svh"
module tb_cpm_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 4;
   localparam int FILT = 3;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, vi_en, t_en, crit_o, crit_oe, al_o, al_oe;
   logic [3:0] th_pin = 4'h3;
   logic [3:0] du_pin = 4'h0;
   logic signed [7:0] pk = 8'h00;
   logic [10:0] sv_s = 11'h000;
   logic [10:0] sv_v = 11'h000;
   logic [10:0] sv_t = 11'h000;
   logic [10:0] sd, vd, td;
   logic s_ok, v_ok, t_ok;
   logic [33:0] expq[$];
   logic [33:0] e_cur;
   int fail_count = 0;
   int comparisons = 0;

   always #4 pclk = ~pclk;

   cpm_ctrl #(.MS_CYCLES(MS), .FILTER_CYCLES(FILT)) u_cpm_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .threshold_strap(th_pin),
      .duration_strap(du_pin), .peak_sample_mv(pk), .sense_data(sd),
      .sense_valid(s_ok), .source_data(vd), .source_valid(v_ok),
      .temp_data(td), .temp_valid(t_ok), .vi_conv_en(vi_en),
      .temp_conv_en(t_en), .vi_limit_chk(), .temp_limit_chk(),
      .crit_out_n_o(crit_o), .crit_out_n_oe(crit_oe), .alert_n_o(al_o),
      .alert_n_oe(al_oe));

   cpm_front_model u_cpm_front_model (
      .pclk(pclk), .presetn(presetn), .vi_en(vi_en), .t_en(t_en),
      .sense_val(sv_s), .source_val(sv_v), .temp_val(sv_t),
      .sense_data(sd), .sense_valid(s_ok), .source_data(vd),
      .source_valid(v_ok), .temp_data(td), .temp_valid(t_ok));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      if (fail_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   // one apb transfer; the expected answer is noted before it starts
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, input logic err, input logic [31:0] exp);
      expq.push_back({~wr, err, exp});
      // one edge of idle so back-to-back calls never drive psel twice
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {20'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 1'b0, exp);
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0, 32'h0);
   endtask : wr

   task automatic set_vals(input logic [10:0] s, v, t);
      sv_s <= s;
      sv_v <= v;
      sv_t <= t;
   endtask : set_vals

   // waits for the trip with a bound, looking on the falling edge where
   // the outputs are settled; the caller checks the outcome
   task automatic wait_trip(input int n);
      @(negedge pclk);
      while (crit_oe !== 1'b1 && n > 0) begin
         @(negedge pclk);
         n--;
      end
   endtask : wait_trip

   function automatic logic [15:0] ratio(input logic [10:0] s, v);
      logic [21:0] p;
      p = (s[10] ? 11'(-s) : s) * v;
      ratio = (p >= 22'h200000) ? 16'hFFFF : p[20:5];
   endfunction : ratio

   ////////////////////////////////////////////////////////////////////////
   // completed transfers take the oldest note off the queue
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
         e_cur = expq.pop_front();
         check({31'h0, pslverr}, {31'h0, e_cur[32]});
         if (e_cur[33])
            check(prdata, e_cur[31:0]);
      end
   end

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #40000;
      fail_count++;
      tally_and_finish();
   end

   initial begin
      logic [10:0] os, ot;
      void'($urandom(32'hECB94AF0));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(`CPM_OFF_CONFIG, 32'h0);
      rd(`CPM_OFF_PEAKCFG, 32'h3);
      apb(1'b0, 12'h020, 32'h0, 1'b1, 32'h0);
      // ratio over the largest magnitude, then random readings
      for (int i = 0; i < 4; i++) begin
         set_vals(i == 0 ? 11'h400 : 11'($urandom),
            i == 0 ? 11'h7FF : 11'($urandom), 11'($urandom));
         repeat (24) @(posedge pclk);
         rd(`CPM_OFF_SENSE, {21'h0, sv_s});
         rd(`CPM_OFF_SOURCE, {21'h0, sv_v});
         rd(`CPM_OFF_POWER, {16'h0, ratio(sv_s, sv_v)});
      end
      wr(`CPM_OFF_ONESHOT, 32'h1);
      rd(`CPM_OFF_STATUS, 32'h0);
      // each reduced mode, then a one-shot that fills the gaps
      for (int m = 1; m < 4; m++) begin
         wr(`CPM_OFF_CONFIG, 32'(m));
         os = sv_s;
         ot = sv_t;
         set_vals(11'($urandom), sv_v, 11'($urandom));
         repeat (24) @(posedge pclk);
         rd(`CPM_OFF_SENSE, {21'h0, m == 1 ? sv_s : os});
         rd(`CPM_OFF_TEMP, {21'h0, m == 2 ? sv_t : ot});
         wr(`CPM_OFF_ONESHOT, 32'h1);
         repeat (24) @(posedge pclk);
         rd(`CPM_OFF_SENSE, {21'h0, sv_s});
         rd(`CPM_OFF_TEMP, {21'h0, sv_t});
         rd(`CPM_OFF_STATUS, 32'h0);
         rd(`CPM_OFF_CONFIG, 32'(m));
      end
      wr(`CPM_OFF_CONFIG, 32'h0);
      // exactly at the strapped threshold is not a peak
      pk <= 8'h19;
      repeat (30) @(posedge pclk);
      check({31'h0, crit_oe}, 32'h0);
      pk <= 8'hE6;
      wait_trip(30);
      check({29'h0, crit_o, crit_oe, al_oe}, 32'h2);
      rd(`CPM_OFF_STATUS, 32'h1);
      wr(`CPM_OFF_CONFIG, 32'hC);
      @(posedge pclk);
      check({30'h0, al_o, al_oe}, 32'h1);
      wr(`CPM_OFF_CONFIG, 32'h8);
      @(posedge pclk);
      check({30'h0, crit_oe, al_oe}, 32'h2);
      pk <= 8'h00;
      repeat (12) @(posedge pclk);
      check({31'h0, crit_oe}, 32'h0);
      rd(`CPM_OFF_STATUS, 32'h0);
      // a dip shorter than the filter must not restart the timer
      wr(`CPM_OFF_PEAKCFG, 32'h10);
      pk <= 8'h14;
      repeat (12) @(posedge pclk);
      pk <= 8'h00;
      repeat (2) @(posedge pclk);
      pk <= 8'h14;
      wait_trip(12);
      check({31'h0, crit_oe}, 32'h1);
      rd(`CPM_OFF_STATUS, 32'h1);
      pk <= 8'h00;
      repeat (12) @(posedge pclk);
      // second reset with random strap codes, captured after release
      th_pin <= 4'($urandom);
      du_pin <= 4'($urandom);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(`CPM_OFF_PEAKCFG, {24'h0, du_pin, th_pin});
      tally_and_finish();
   end
endmodule : tb_cpm_ctrl
